// ### verilog/odr_pkg.sv
package odr_pkg;
   // Reorder buffer and buffering sizes
   localparam int RBF_DEPTH = 16;
   localparam int FIFO_DEPTH = 16;
   localparam int PC_W = 32;
   localparam int DIST_W = 4;
   localparam int CLS_W = 3;
   // Dispatch and retirement widths
   localparam int DISP_MAX = 6;
   localparam int RET_MAX = 3;
   localparam int CMPL_PORTS = 3;
   // Dispatch port numbers
   localparam int P_ALU0 = 0;
   localparam int P_ALU1 = 1;
   localparam int P_FP = 2;
   localparam int P_LD = 3;
   localparam int P_ST = 4;
   localparam int P_BR = 5;
   // Front-end word layout inside the buffer
   localparam int UOP_PC_LSB = 0;
   localparam int UOP_CLS_LSB = 32;
   localparam int UOP_DA_LSB = 35;
   localparam int UOP_DB_LSB = 39;
   localparam int UOP_W = 43;
   // Micro-operation classes
   typedef enum logic [2:0] {
      CLS_ALU = 3'h0,
      CLS_FP = 3'h1,
      CLS_LD = 3'h2,
      CLS_ST = 3'h3,
      CLS_BR = 3'h4
   } odr_cls_t;
endpackage : odr_pkg

// ### verilog/odr_fifo.sv
`timescale 1ns/1ps
module odr_fifo #(
   parameter int W = odr_pkg::UOP_W,
   parameter int DEPTH = odr_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic clr,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   // Depth must be a power of two; pointers wrap naturally
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp, rp, next_wp, next_rp;
   logic [CW-1:0] cnt, next_cnt;
   logic rdy, next_rdy;
   logic wr, rd;

   assign wr = in_valid & rdy;
   assign rd = out_valid & out_ready;
   assign out_valid = cnt != '0;
   assign out_data = mem[rp];
   assign in_ready = rdy;

   always_comb begin
      next_wp = wr ? wp + AW'(1) : wp;
      next_rp = rd ? rp + AW'(1) : rp;
      next_cnt = cnt + CW'(wr) - CW'(rd);
      if (clr) begin
         next_wp = '0;
         next_rp = '0;
         next_cnt = '0;
      end
      // Registered full flag keeps the ready port glitch free
      next_rdy = next_cnt != CW'(DEPTH);
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
         rdy <= 1'b0;
      end else begin
         wp <= next_wp;
         rp <= next_rp;
         cnt <= next_cnt;
         rdy <= next_rdy;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (wr) begin
         mem[wp] <= in_data;
      end
   end
endmodule : odr_fifo

// ### verilog/odr_core.sv
`timescale 1ns/1ps
// What this block does
// RULE_01: The front end hands over micro-operations strictly in program order.
// RULE_02: No more than six micro-operations are dispatched in one clock cycle.
// RULE_03: A micro-operation may start, in any order, once its inputs are ready and its pipe is free.
// RULE_04: Ready younger micro-operations go ahead of a stalled older one.
// RULE_05: Each pipe other than the floating-point one may take a new micro-operation every cycle.
// RULE_06: Two integer operations may start per cycle, floating-point ones at most every second cycle.
// RULE_07: Basic integer results are available within one core cycle, as from a double-rate unit.
// RULE_08: Results update architectural state only in program order.
// RULE_09: Stores are committed one at a time in program order to keep total store order.
// RULE_10: Exceptions are raised only for the oldest entry, never speculatively, leaving a restartable state.
// RULE_11: A micro-operation retires once it has completed and written its result.
// RULE_12: At most three micro-operations retire per cycle.
// RULE_13: The reorder buffer holds completed work, commits it in order and orders exceptions.
// RULE_14: Retired branches send their resolved target to the branch target buffer.
// RULE_15: An exception at the oldest entry discards all younger entries before fetch restarts.
// RULE_16: Intake from the front end stalls while the reorder buffer is full.
module odr_core #(
   parameter int RBF_DEPTH = odr_pkg::RBF_DEPTH,
   parameter int FIFO_DEPTH = odr_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Front end
   input wire logic fe_valid,
   output logic fe_ready,
   input wire logic [odr_pkg::PC_W-1:0] fe_pc,
   input wire logic [odr_pkg::CLS_W-1:0] fe_cls,
   input wire logic [odr_pkg::DIST_W-1:0] fe_dist_a,
   input wire logic [odr_pkg::DIST_W-1:0] fe_dist_b,
   // Dispatch to execution pipes
   input wire logic [odr_pkg::DISP_MAX-1:0] pipe_free,
   output logic [odr_pkg::DISP_MAX-1:0] disp_valid,
   output logic [odr_pkg::DISP_MAX*$clog2(RBF_DEPTH)-1:0] disp_idx,
   output logic [odr_pkg::DISP_MAX*odr_pkg::PC_W-1:0] disp_pc,
   // Completion from execution pipes
   input wire logic [odr_pkg::CMPL_PORTS-1:0] cmpl_valid,
   input wire logic [odr_pkg::CMPL_PORTS*$clog2(RBF_DEPTH)-1:0] cmpl_idx,
   input wire logic [odr_pkg::CMPL_PORTS-1:0] cmpl_exc,
   input wire logic [odr_pkg::CMPL_PORTS*odr_pkg::PC_W-1:0] cmpl_tgt,
   // Retirement
   output logic [odr_pkg::RET_MAX-1:0] ret_valid,
   output logic [odr_pkg::RET_MAX*$clog2(RBF_DEPTH)-1:0] ret_idx,
   output logic st_commit_valid,
   output logic [$clog2(RBF_DEPTH)-1:0] st_commit_idx,
   // Branch target buffer update
   output logic tgt_upd_valid,
   output logic [odr_pkg::PC_W-1:0] tgt_upd_pc,
   output logic [odr_pkg::PC_W-1:0] tgt_upd_target,
   // Exception and restart
   output logic exc_valid,
   output logic [odr_pkg::PC_W-1:0] exc_pc
);
   localparam int IW = $clog2(RBF_DEPTH);
   localparam int PW = odr_pkg::PC_W;
   localparam int DW = odr_pkg::DIST_W;
   localparam int NP = odr_pkg::DISP_MAX;

   function automatic logic [IW-1:0] wrap(input logic [IW-1:0] base, input int off);
      return base + IW'(off);
   endfunction : wrap

   // Entry state
   logic [RBF_DEPTH-1:0] vld, iss, done, exc, dep_a, dep_b;
   logic [RBF_DEPTH-1:0] next_vld, next_iss, next_done, next_exc, next_dep_a, next_dep_b;
   logic [odr_pkg::CLS_W-1:0] cls [RBF_DEPTH];
   logic [odr_pkg::CLS_W-1:0] next_cls [RBF_DEPTH];
   logic [PW-1:0] pc [RBF_DEPTH];
   logic [PW-1:0] next_pc [RBF_DEPTH];
   logic [PW-1:0] tgt [RBF_DEPTH];
   logic [PW-1:0] next_tgt [RBF_DEPTH];
   logic [IW-1:0] src_a [RBF_DEPTH];
   logic [IW-1:0] next_src_a [RBF_DEPTH];
   logic [IW-1:0] src_b [RBF_DEPTH];
   logic [IW-1:0] next_src_b [RBF_DEPTH];
   logic [IW-1:0] head, tail, next_head, next_tail;
   logic [IW:0] cnt, next_cnt;
   logic fp_wait, next_fp_wait;
   // Registered outputs
   logic [NP-1:0] next_disp_valid;
   logic [NP*IW-1:0] next_disp_idx;
   logic [NP*PW-1:0] next_disp_pc;
   logic [odr_pkg::RET_MAX-1:0] next_ret_valid;
   logic [odr_pkg::RET_MAX*IW-1:0] next_ret_idx;
   logic next_st_commit_valid, next_tgt_upd_valid, next_exc_valid;
   logic [IW-1:0] next_st_commit_idx;
   logic [PW-1:0] next_tgt_upd_pc, next_tgt_upd_target, next_exc_pc;
   // Buffer drain side
   logic uq_valid, uq_ready, flush, alloc;
   logic [odr_pkg::UOP_W-1:0] uq_data, fe_word;
   logic [DW-1:0] da, db;

   assign fe_word = {fe_dist_b, fe_dist_a, fe_cls, fe_pc};
   assign da = uq_data[odr_pkg::UOP_DA_LSB +: DW];
   assign db = uq_data[odr_pkg::UOP_DB_LSB +: DW];

   odr_fifo #(.W(odr_pkg::UOP_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .clr(flush),
      .in_valid(fe_valid),
      .in_ready(fe_ready),
      .in_data(fe_word),
      .out_valid(uq_valid),
      .out_ready(uq_ready),
      .out_data(uq_data)
   );

   always_comb begin
      logic [IW-1:0] k;
      logic [IW-1:0] t;
      logic [1:0] nret;
      logic stop, st_used, br_used;
      int p;
      k = '0;
      t = tail;
      nret = 2'h0;
      stop = 1'b0;
      st_used = 1'b0;
      br_used = 1'b0;
      p = 0;
      flush = 1'b0;
      next_vld = vld;
      next_iss = iss;
      next_done = done;
      next_exc = exc;
      next_dep_a = dep_a;
      next_dep_b = dep_b;
      next_cls = cls;
      next_pc = pc;
      next_tgt = tgt;
      next_src_a = src_a;
      next_src_b = src_b;
      next_fp_wait = 1'b0;
      next_disp_valid = '0;
      next_disp_idx = disp_idx;
      next_disp_pc = disp_pc;
      next_ret_valid = '0;
      next_ret_idx = ret_idx;
      next_st_commit_valid = 1'b0;
      next_st_commit_idx = st_commit_idx;
      next_tgt_upd_valid = 1'b0;
      next_tgt_upd_pc = tgt_upd_pc;
      next_tgt_upd_target = tgt_upd_target;
      next_exc_valid = 1'b0;
      next_exc_pc = exc_pc;
      // Completions land in the reorder buffer; stale indices are dropped
      for (int c = 0; c < odr_pkg::CMPL_PORTS; c++) begin
         k = cmpl_idx[c*IW +: IW];
         if (cmpl_valid[c] && vld[k] && iss[k]) begin // see RULE_13
            next_done[k] = 1'b1;
            next_exc[k] = cmpl_exc[c];
            next_tgt[k] = cmpl_tgt[c*PW +: PW];
         end
      end
      // Wake-up: a source that is done or gone no longer blocks
      for (int i = 0; i < RBF_DEPTH; i++) begin
         if (dep_a[i] && (done[src_a[i]] || !vld[src_a[i]])) begin // see RULE_03
            next_dep_a[i] = 1'b0;
         end
         if (dep_b[i] && (done[src_b[i]] || !vld[src_b[i]])) begin
            next_dep_b[i] = 1'b0;
         end
      end
      // Oldest-first pick per pipe; blocked entries are simply skipped
      for (int off = 0; off < RBF_DEPTH; off++) begin
         k = wrap(head, off);
         if (vld[k] && !iss[k] && !dep_a[k] && !dep_b[k]) begin // see RULE_03, see RULE_04
            p = -1;
            case (cls[k])
               odr_pkg::CLS_ALU: begin
                  if (!next_disp_valid[odr_pkg::P_ALU0] && pipe_free[odr_pkg::P_ALU0]) begin // see RULE_06
                     p = odr_pkg::P_ALU0;
                  end else if (!next_disp_valid[odr_pkg::P_ALU1] && pipe_free[odr_pkg::P_ALU1]) begin
                     p = odr_pkg::P_ALU1;
                  end
               end
               odr_pkg::CLS_FP: begin
                  if (!fp_wait) begin // see RULE_06
                     p = odr_pkg::P_FP;
                  end
               end
               odr_pkg::CLS_LD: p = odr_pkg::P_LD;
               odr_pkg::CLS_ST: p = odr_pkg::P_ST;
               odr_pkg::CLS_BR: p = odr_pkg::P_BR;
               default: p = -1;
            endcase
            if (p >= 0 && !next_disp_valid[p] && pipe_free[p]) begin // see RULE_02, see RULE_05
               next_disp_valid[p] = 1'b1;
               next_disp_idx[p*IW +: IW] = k;
               next_disp_pc[p*PW +: PW] = pc[k];
               next_iss[k] = 1'b1;
               // Double-rate integer unit: result is ready by the next edge
               if (cls[k] == odr_pkg::CLS_ALU) begin
                  next_done[k] = 1'b1; // see RULE_07
               end
               if (p == odr_pkg::P_FP) begin
                  next_fp_wait = 1'b1;
               end
            end
         end
      end
      // In-order retirement from the head, up to three per cycle
      for (int off = 0; off < odr_pkg::RET_MAX; off++) begin // see RULE_12
         k = wrap(head, off);
         if (stop || !vld[k] || !done[k]) begin // see RULE_08, see RULE_11
            stop = 1'b1;
         end else if (exc[k]) begin
            // Only the oldest entry may raise; younger faults wait their turn
            if (off == 0) begin // see RULE_10
               flush = 1'b1;
               next_exc_valid = 1'b1;
               next_exc_pc = pc[k];
            end
            stop = 1'b1;
         end else if ((cls[k] == odr_pkg::CLS_ST && st_used) || (cls[k] == odr_pkg::CLS_BR && br_used)) begin
            stop = 1'b1; // see RULE_09
         end else begin
            next_ret_valid[off] = 1'b1;
            next_ret_idx[off*IW +: IW] = k;
            next_vld[k] = 1'b0;
            nret = nret + 2'h1;
            if (cls[k] == odr_pkg::CLS_ST) begin
               st_used = 1'b1;
               next_st_commit_valid = 1'b1; // see RULE_09
               next_st_commit_idx = k;
            end
            if (cls[k] == odr_pkg::CLS_BR) begin
               br_used = 1'b1;
               next_tgt_upd_valid = 1'b1; // see RULE_14
               next_tgt_upd_pc = pc[k];
               next_tgt_upd_target = tgt[k];
            end
         end
      end
      next_head = head + IW'(nret);
      // Allocation, one per cycle, held off while full
      uq_ready = (cnt != (IW + 1)'(RBF_DEPTH)) && !flush; // see RULE_16
      alloc = uq_valid && uq_ready; // see RULE_01
      if (alloc) begin
         next_vld[t] = 1'b1;
         next_iss[t] = 1'b0;
         next_done[t] = 1'b0;
         next_exc[t] = 1'b0;
         next_cls[t] = uq_data[odr_pkg::UOP_CLS_LSB +: odr_pkg::CLS_W];
         next_pc[t] = uq_data[odr_pkg::UOP_PC_LSB +: PW];
         next_src_a[t] = t - IW'(da);
         next_src_b[t] = t - IW'(db);
         next_dep_a[t] = (da != '0) && ((IW + 1)'(da) <= cnt) && !done[t - IW'(da)];
         next_dep_b[t] = (db != '0) && ((IW + 1)'(db) <= cnt) && !done[t - IW'(db)];
      end
      next_tail = tail + IW'(alloc);
      next_cnt = cnt + (IW + 1)'(alloc) - (IW + 1)'(nret);
      // Fault at the head throws away every younger entry and its dispatch
      if (flush) begin // see RULE_15
         next_vld = '0;
         next_head = '0;
         next_tail = '0;
         next_cnt = '0;
         next_disp_valid = '0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         vld <= '0;
         iss <= '0;
         done <= '0;
         exc <= '0;
         dep_a <= '0;
         dep_b <= '0;
         head <= '0;
         tail <= '0;
         cnt <= '0;
         fp_wait <= 1'b0;
         disp_valid <= '0;
         disp_idx <= '0;
         disp_pc <= '0;
         ret_valid <= '0;
         ret_idx <= '0;
         st_commit_valid <= 1'b0;
         st_commit_idx <= '0;
         tgt_upd_valid <= 1'b0;
         tgt_upd_pc <= '0;
         tgt_upd_target <= '0;
         exc_valid <= 1'b0;
         exc_pc <= '0;
      end else begin
         vld <= next_vld;
         iss <= next_iss;
         done <= next_done;
         exc <= next_exc;
         dep_a <= next_dep_a;
         dep_b <= next_dep_b;
         head <= next_head;
         tail <= next_tail;
         cnt <= next_cnt;
         fp_wait <= next_fp_wait;
         disp_valid <= next_disp_valid;
         disp_idx <= next_disp_idx;
         disp_pc <= next_disp_pc;
         ret_valid <= next_ret_valid;
         ret_idx <= next_ret_idx;
         st_commit_valid <= next_st_commit_valid;
         st_commit_idx <= next_st_commit_idx;
         tgt_upd_valid <= next_tgt_upd_valid;
         tgt_upd_pc <= next_tgt_upd_pc;
         tgt_upd_target <= next_tgt_upd_target;
         exc_valid <= next_exc_valid;
         exc_pc <= next_exc_pc;
      end
   end

   // Payload arrays need no reset; valid bits guard them
   always_ff @(posedge ref_clk) begin
      cls <= next_cls;
      pc <= next_pc;
      tgt <= next_tgt;
      src_a <= next_src_a;
      src_b <= next_src_b;
   end

   // Checks
   logic head_done, head_exc, young_first;
   logic [IW-1:0] a0_idx, ld_idx, r0_idx, r1_idx;
   assign head_done = vld[head] && done[head] && !exc[head];
   assign head_exc = vld[head] && done[head] && exc[head];
   assign a0_idx = disp_idx[odr_pkg::P_ALU0*IW +: IW];
   assign ld_idx = disp_idx[odr_pkg::P_LD*IW +: IW];
   assign r0_idx = ret_idx[0 +: IW];
   assign r1_idx = ret_idx[IW +: IW];
   assign young_first = vld[head] && !iss[head] && (disp_valid != '0);

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   property p_disp_free;
      $countones(disp_valid) <= $countones($past(pipe_free));
   endproperty
   a_disp_free: assert property (p_disp_free) else $error("dispatch exceeds free pipes"); // see RULE_02
   property p_ld_ready;
      disp_valid[odr_pkg::P_LD] && vld[ld_idx] |-> iss[ld_idx] && !dep_a[ld_idx] && !dep_b[ld_idx];
   endproperty
   a_ld_ready: assert property (p_ld_ready) else $error("load dispatched with pending source"); // see RULE_03
   property p_alu_pair;
      disp_valid[odr_pkg::P_ALU1] && $past(pipe_free[odr_pkg::P_ALU0]) |-> disp_valid[odr_pkg::P_ALU0];
   endproperty
   a_alu_pair: assert property (p_alu_pair) else $error("second integer pipe used before first"); // see RULE_06
   property p_fp_rate;
      disp_valid[odr_pkg::P_FP] |=> !disp_valid[odr_pkg::P_FP];
   endproperty
   a_fp_rate: assert property (p_fp_rate) else $error("floating-point start too soon"); // see RULE_06
   property p_alu_half;
      disp_valid[odr_pkg::P_ALU0] && vld[a0_idx] |-> done[a0_idx];
   endproperty
   a_alu_half: assert property (p_alu_half) else $error("integer result not ready"); // see RULE_07
   property p_ret_order;
      ret_valid[1] |-> ret_valid[0] && (r1_idx == r0_idx + IW'(1));
   endproperty
   a_ret_order: assert property (p_ret_order) else $error("retirement out of order"); // see RULE_08
   property p_ret_done;
      ret_valid[0] |-> $past(head_done);
   endproperty
   a_ret_done: assert property (p_ret_done) else $error("retired entry was not complete"); // see RULE_11
   property p_st_commit;
      st_commit_valid |-> ret_valid[0] && !exc_valid;
   endproperty
   a_st_commit: assert property (p_st_commit) else $error("store commit without retirement"); // see RULE_09
   property p_exc_flush;
      exc_valid |-> $past(head_exc) && cnt == '0 && disp_valid == '0 && ret_valid == '0;
   endproperty
   a_exc_flush: assert property (p_exc_flush) else $error("exception not clean"); // see RULE_10
   property p_full_stall;
      cnt == (IW + 1)'(RBF_DEPTH) |-> !alloc ##1 cnt <= (IW + 1)'(RBF_DEPTH);
   endproperty
   a_full_stall: assert property (p_full_stall) else $error("allocation while full"); // see RULE_16
   property p_tgt_upd;
      tgt_upd_valid |-> ret_valid != '0;
   endproperty
   a_tgt_upd: assert property (p_tgt_upd) else $error("target update without retirement"); // see RULE_14

   c_two_alu: cover property (disp_valid[odr_pkg::P_ALU0] && disp_valid[odr_pkg::P_ALU1]);
   c_three_ret: cover property (&ret_valid);
   c_young_first: cover property (young_first);
   c_exc: cover property (exc_valid);
endmodule : odr_core

// ### verif/odr_pipe_model.sv
`timescale 1ns/1ps
module odr_pipe_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Bench controls
   input wire logic [5:0] busy,
   input wire logic [31:0] fault_pc,
   input wire logic [7:0] slow_lat,
   // Core side
   input wire logic [5:0] disp_valid,
   input wire logic [23:0] disp_idx,
   input wire logic [191:0] disp_pc,
   input wire logic exc_valid,
   output logic [5:0] pipe_free,
   output logic [2:0] cmpl_valid,
   output logic [11:0] cmpl_idx,
   output logic [2:0] cmpl_exc,
   output logic [95:0] cmpl_tgt
);
   int due[16];
   logic [31:0] pcs[16];
   int n;
   // Idle lines toggle so stale values are never mistaken for fresh ones
   always @(posedge ref_clk) begin
      #1;
      cmpl_valid = 3'h0;
      cmpl_idx = nrst ? ~cmpl_idx : 12'h000;
      cmpl_exc = nrst ? ~cmpl_exc : 3'h0;
      cmpl_tgt = nrst ? ~cmpl_tgt : '0;
      pipe_free = ~busy;
      n = 0;
      for (int i = 0; i < 16; i++) begin
         // Flushed entries never report, their indices get reused
         if (!nrst || exc_valid) due[i] = 0;
         else if (due[i] == 1 && n < 3) begin
            cmpl_valid[n] = 1'b1;
            cmpl_idx[n*4+:4] = i[3:0];
            cmpl_exc[n] = (pcs[i] === fault_pc);
            cmpl_tgt[n*32+:32] = pcs[i] + 32'h0000_0100;
            n++;
            due[i] = 0;
         end else if (due[i] > 1) due[i]--;
      end
      // Integer pipes need no report, loads take the slow latency
      for (int p = 2; p < 6; p++) begin
         if (nrst && !exc_valid && disp_valid[p]) begin
            due[disp_idx[p*4+:4]] = (p == 3) ? int'(slow_lat) : 2;
            pcs[disp_idx[p*4+:4]] = disp_pc[p*32+:32];
         end
      end
   end
endmodule : odr_pipe_model

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
   logic ref_clk, nrst, fe_valid, fe_ready, st_commit_valid, tgt_upd_valid, exc_valid, prev_fp;
   logic [31:0] fe_pc, tgt_upd_pc, tgt_upd_target, exc_pc, fault_pc, last_ret, st_pc, upd_pc;
   logic [2:0] fe_cls, cmpl_valid, cmpl_exc, ret_valid;
   logic [3:0] fe_dist_a, fe_dist_b, st_commit_idx;
   logic [5:0] pipe_free, disp_valid, busy;
   logic [23:0] disp_idx;
   logic [191:0] disp_pc;
   logic [11:0] cmpl_idx, ret_idx;
   logic [95:0] cmpl_tgt;
   logic [7:0] slow_lat;
   logic [31:0] idx_pc[16];
   int disp_at[256];
   int ret_at[256];
   int fail_count, compares, cyc, ret_total, st_total, upd_total, exc_total, pc_n;

   odr_core odr_core_i (.ref_clk(ref_clk), .nrst(nrst), .fe_valid(fe_valid), .fe_ready(fe_ready), .fe_pc(fe_pc),
      .fe_cls(fe_cls), .fe_dist_a(fe_dist_a), .fe_dist_b(fe_dist_b), .pipe_free(pipe_free),
      .disp_valid(disp_valid), .disp_idx(disp_idx), .disp_pc(disp_pc), .cmpl_valid(cmpl_valid),
      .cmpl_idx(cmpl_idx), .cmpl_exc(cmpl_exc), .cmpl_tgt(cmpl_tgt), .ret_valid(ret_valid), .ret_idx(ret_idx),
      .st_commit_valid(st_commit_valid), .st_commit_idx(st_commit_idx), .tgt_upd_valid(tgt_upd_valid),
      .tgt_upd_pc(tgt_upd_pc), .tgt_upd_target(tgt_upd_target), .exc_valid(exc_valid), .exc_pc(exc_pc));
   odr_pipe_model odr_pipe_model_i (.ref_clk(ref_clk), .nrst(nrst), .busy(busy), .fault_pc(fault_pc),
      .slow_lat(slow_lat), .disp_valid(disp_valid), .disp_idx(disp_idx), .disp_pc(disp_pc),
      .exc_valid(exc_valid), .pipe_free(pipe_free), .cmpl_valid(cmpl_valid), .cmpl_idx(cmpl_idx),
      .cmpl_exc(cmpl_exc), .cmpl_tgt(cmpl_tgt));

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic end_sim();
      $display("checks %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   initial begin
      #50000;
      fail_count++;
      end_sim();
   end

   // Monitor samples settled outputs
   always @(posedge ref_clk) begin
      #2;
      cyc++;
      for (int p = 0; p < 6; p++) begin
         if (disp_valid[p]) begin
            idx_pc[disp_idx[p*4+:4]] = disp_pc[p*32+:32];
            disp_at[disp_pc[p*32+:8]] = cyc;
         end
      end
      if (disp_valid[2]) chk("fp_rate", 32'h0, 32'(prev_fp));
      prev_fp = disp_valid[2];
      if (ret_valid != 3'h0) chk("ret_fill", 32'h1, 32'(ret_valid inside {3'h1, 3'h3, 3'h7}));
      for (int j = 0; j < 3; j++) begin
         if (ret_valid[j]) begin
            chk("ret_order", 32'h1, 32'(idx_pc[ret_idx[j*4+:4]] > last_ret));
            last_ret = idx_pc[ret_idx[j*4+:4]];
            ret_at[last_ret[7:0]] = cyc;
            ret_total++;
         end
      end
      if (st_commit_valid) chk("st_with_ret", 32'h1, 32'(ret_valid != 3'h0));
      if (st_commit_valid) st_total++;
      if (st_commit_valid) st_pc = idx_pc[st_commit_idx];
      if (tgt_upd_valid) upd_pc = tgt_upd_pc;
      if (tgt_upd_valid) chk("tgt_upd", tgt_upd_pc + 32'h0000_0100, tgt_upd_target);
      if (tgt_upd_valid) upd_total++;
      if (exc_valid) exc_total++;
      if (exc_valid) last_ret = 32'h0;
   end

   // Front end keeps program order: pc rises by one per word
   task automatic push(input logic [2:0] cls, input logic [3:0] da, input logic [3:0] db = 4'h0);
      int n;
      n = 0;
      #1;
      fe_valid = 1'b1;
      fe_pc = pc_n;
      fe_cls = cls;
      fe_dist_a = da;
      fe_dist_b = db;
      do begin
         @(posedge ref_clk);
         n++;
      end while (!fe_ready && n < 200);
      pc_n++;
   endtask : push

   task automatic idle(input int n);
      #1;
      fe_valid = 1'b0;
      fe_pc = ~fe_pc;
      repeat (n) @(posedge ref_clk);
   endtask : idle

   task automatic wait_ret(input int target);
      int n;
      n = 0;
      while (ret_total < target && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
      repeat (3) @(posedge ref_clk);
      chk("ret_count", 32'(target), 32'(ret_total));
   endtask : wait_ret

   task automatic t_reset();
      repeat (10) @(posedge ref_clk);
      #1;
      chk("rst_out", 32'h0, 32'({fe_ready, disp_valid, ret_valid, exc_valid, st_commit_valid, tgt_upd_valid}));
      nrst = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("ready_after_rst", 32'h1, 32'(fe_ready));
      @(posedge ref_clk);
   endtask : t_reset

   task automatic t_alu();
      int p;
      p = pc_n;
      push(odr_pkg::CLS_ALU, 4'h0);
      idle(1);
      wait_ret(ret_total + 1);
      chk("alu_ret_lat", 32'(disp_at[p] + 1), 32'(ret_at[p]));
   endtask : t_alu

   task automatic t_six();
      int p, b, s, u;
      p = pc_n;
      b = ret_total;
      s = st_total;
      u = upd_total;
      busy = 6'h3F;
      for (int k = 0; k < 6; k++) push((k < 2) ? 3'h0 : 3'(k - 1), 4'h0);
      idle(4);
      busy = 6'h00;
      wait_ret(b + 6);
      for (int k = 1; k < 6; k++)
         chk("six_way", 32'(disp_at[p]), 32'(disp_at[p+k]));
      chk("st_count", 32'(s + 1), 32'(st_total));
      chk("upd_count", 32'(u + 1), 32'(upd_total));
      chk("st_pc", 32'(p + 4), st_pc);
      chk("upd_pc", 32'(p + 5), upd_pc);
   endtask : t_six

   task automatic t_fp();
      int p;
      p = pc_n;
      busy = 6'h04;
      push(odr_pkg::CLS_FP, 4'h0);
      push(odr_pkg::CLS_FP, 4'h0);
      idle(4);
      busy = 6'h00;
      wait_ret(ret_total + 2);
      chk("fp_gap", 32'(disp_at[p] + 2), 32'(disp_at[p+1]));
   endtask : t_fp

   task automatic t_ooo();
      int p;
      p = pc_n;
      slow_lat = 8'h14;
      push(odr_pkg::CLS_LD, 4'h0);
      push(odr_pkg::CLS_ALU, 4'h1);
      push(odr_pkg::CLS_ALU, 4'h0);
      push(odr_pkg::CLS_ALU, 4'h0, 4'h3);
      idle(1);
      wait_ret(ret_total + 4);
      chk("young_first", 32'h1, 32'(disp_at[p+2] < disp_at[p+1]));
      chk("dep_waits", 32'h1, 32'(disp_at[p+1] > disp_at[p] + 10));
      chk("dep_b_waits", 32'h1, 32'(disp_at[p+3] > disp_at[p] + 10));
      slow_lat = 8'h02;
   endtask : t_ooo

   task automatic t_exc();
      int b, e, n;
      b = ret_total;
      e = exc_total;
      n = 0;
      fault_pc = pc_n + 1;
      push(odr_pkg::CLS_ALU, 4'h0);
      push(odr_pkg::CLS_LD, 4'h0);
      push(odr_pkg::CLS_ALU, 4'h0);
      push(odr_pkg::CLS_ALU, 4'h1);
      idle(1);
      while (exc_total == e && n < 100) begin
         @(posedge ref_clk);
         n++;
      end
      chk("exc_pc", fault_pc, exc_pc);
      repeat (5) @(posedge ref_clk);
      chk("flushed", 32'(b + 1), 32'(ret_total));
      fault_pc = 32'hFFFF_FFFF;
      push(odr_pkg::CLS_ALU, 4'h0);
      idle(1);
      wait_ret(b + 2);
   endtask : t_exc

   task automatic t_full();
      int b, n, q;
      b = ret_total;
      n = 0;
      q = pc_n;
      busy = 6'h3F;
      #1;
      fe_valid = 1'b1;
      fe_cls = odr_pkg::CLS_ALU;
      fe_dist_a = 4'h0;
      fe_pc = pc_n;
      repeat (60) begin
         @(posedge ref_clk);
         if (fe_ready) n++;
         if (fe_ready) pc_n++;
         #1 fe_pc = pc_n;
      end
      chk("full_refuse", 32'h0, 32'(fe_ready));
      chk("full_count", 32'(odr_pkg::RBF_DEPTH + odr_pkg::FIFO_DEPTH), 32'(n));
      idle(1);
      busy = 6'h00;
      wait_ret(b + n);
      chk("pipe_rate", 32'(disp_at[q] + 1), 32'(disp_at[q + 2]));
   endtask : t_full

   initial begin
      nrst = 1'b0;
      fe_valid = 1'b0;
      fe_pc = 32'h0;
      fe_cls = 3'h0;
      fe_dist_a = 4'h0;
      fe_dist_b = 4'h0;
      busy = 6'h00;
      fault_pc = 32'hFFFF_FFFF;
      slow_lat = 8'h02;
      last_ret = 32'h0;
      prev_fp = 1'b0;
      pc_n = 16;
      t_reset();
      t_alu();
      t_six();
      t_fp();
      t_ooo();
      t_exc();
      t_full();
      end_sim();
   end
endmodule : tb
